// ### rtl/ac_switch_pkg.sv
package ac_switch_pkg;
  // ==========================================================
  // Recovery timer and reset values
  // ==========================================================
  localparam int unsigned RAMP_CYCLES = 1024;
  localparam int unsigned RAMP_CNT_W = 11;
  localparam logic [10:0] RAMP_CNT_RST = 11'h000;
  localparam logic GATE_RST = 1'b0;

  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [5:0] {
    ST_LOCKOUT = 6'h01,
    ST_QUALIFY = 6'h02,
    ST_TIMER = 6'h04,
    ST_ARM_ON = 6'h08,
    ST_ON = 6'h10,
    ST_TRIP = 6'h20
  } seq_state_t;

  // Cap ramp phases
  typedef enum logic [1:0] {
    CAP_DOWN = 2'h1,
    CAP_UP = 2'h2
  } cap_phase_t;
endpackage : ac_switch_pkg

// ### rtl/sense_if.sv
// ============================================================
// Synchronised sense levels and zero-crossing edges
// ============================================================
interface sense_if;
  logic supply_ok;
  logic in_window;
  logic ov_pos;
  logic ov_neg;
  logic over_temp;
  logic temp_released;
  logic cap_at_high;
  logic cap_at_low;
  logic zc_rise;
  logic zc_fall;
  modport producer (
    output supply_ok, in_window, ov_pos, ov_neg, over_temp, temp_released,
    output cap_at_high, cap_at_low, zc_rise, zc_fall
  );
  modport consumer (
    input supply_ok, in_window, ov_pos, ov_neg, over_temp, temp_released,
    input cap_at_high, cap_at_low, zc_rise, zc_fall
  );
endinterface : sense_if

// ### rtl/input_sync.sv
// ============================================================
// Two-stage synchronisers and zero-crossing edge detect
// ============================================================
module input_sync
  import ac_switch_pkg::*;
#(
  parameter int unsigned N_IN = 9
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [8:0] raw_i,
  sense_if.producer sense
);
  logic [N_IN-1:0] stage1;
  logic [N_IN-1:0] stage2;
  logic zc_prev;
  logic [N_IN-1:0] next_stage1;
  logic [N_IN-1:0] next_stage2;
  logic next_zc_prev;

  // Stage1 feeds only stage2; everything else reads stage2
  always_comb begin
    next_stage1 = raw_i;
    next_stage2 = stage1;
    next_zc_prev = stage2[8];
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
      zc_prev <= 1'b0;
    end else begin
      stage1 <= next_stage1; // see [RULE11]
      stage2 <= next_stage2;
      zc_prev <= next_zc_prev;
    end
  end

  // One edge pulse per crossing, taken from settled levels
  assign sense.supply_ok = stage2[0];
  assign sense.in_window = stage2[1];
  assign sense.ov_pos = stage2[2];
  assign sense.ov_neg = stage2[3];
  assign sense.over_temp = stage2[4];
  assign sense.temp_released = stage2[5];
  assign sense.cap_at_high = stage2[6];
  assign sense.cap_at_low = stage2[7];
  assign sense.zc_rise = stage2[8] & ~zc_prev; // see [RULE11]
  assign sense.zc_fall = ~stage2[8] & zc_prev; // see [RULE11]
endmodule : input_sync

// ### rtl/recovery_timer.sv
// ============================================================
// Capacitor ramp controller and ramp cycle counter
// ============================================================
module recovery_timer
  import ac_switch_pkg::*;
#(
  parameter int unsigned CYCLES = RAMP_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  sense_if.consumer sense,
  output logic sink_on_o,
  output logic source_on_o,
  output logic done_o,
  output logic [10:0] count_o
);
  cap_phase_t phase;
  cap_phase_t next_phase;
  logic [10:0] count;
  logic [10:0] next_count;
  logic done;
  logic next_done;

  // Down first, then up; one full down-up trip is one count
  always_comb begin
    next_phase = phase;
    next_count = count;
    next_done = done;
    if (!run_i) begin
      next_phase = CAP_DOWN;
      next_count = RAMP_CNT_RST; // see [RULE8]
      next_done = 1'b0;
    end else if (!done) begin
      case (phase)
        CAP_DOWN: begin
          if (sense.cap_at_low) next_phase = CAP_UP; // see [RULE6]
        end
        CAP_UP: begin
          if (sense.cap_at_high) begin
            next_phase = CAP_DOWN;
            next_count = count + 11'h001;
            if (count == 11'(CYCLES - 1)) next_done = 1'b1; // see [RULE6]
          end
        end
        default: next_phase = CAP_DOWN;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase <= CAP_DOWN;
      count <= RAMP_CNT_RST;
      done <= 1'b0;
    end else begin
      phase <= next_phase;
      count <= next_count;
      done <= next_done;
    end
  end

  // Current sources idle once the interval is done or not running
  assign sink_on_o = run_i & ~done & (phase == CAP_DOWN);
  assign source_on_o = run_i & ~done & (phase == CAP_UP);
  assign done_o = done;
  assign count_o = count;
endmodule : recovery_timer

// ### rtl/ac_switch_ovp_sequencer.sv
// Contract
// [RULE1] Drive off until supply rises; hysteretic lockout
// [RULE2] Turn-on starts only inside start-up window
// [RULE3] Over-voltage while on trips at crossing
// [RULE4] Positive trip on falling, negative on rising
// [RULE5] Timer starts after one full in-window cycle
// [RULE6] Count 1024 down-up capacitor ramp cycles
// [RULE7] Switch on at next rising crossing
// [RULE8] Leaving window resets timer, requalify
// [RULE9] Over-temperature turns off at falling crossing
// [RULE10] After thermal trip, wait release, full restart
// [RULE11] Synchronise inputs, one decision per edge
// [RULE12] Reset or lockout clears everything, drive off; lockout keeps the thermal latch
module ac_switch_ovp_sequencer
  import ac_switch_pkg::*;
#(
  parameter int unsigned CYCLES = RAMP_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic supply_lockout_ok_i,
  input wire logic sense_in_window_i,
  input wire logic overvoltage_pos_i,
  input wire logic overvoltage_neg_i,
  input wire logic over_temp_i,
  input wire logic temp_released_i,
  input wire logic cap_at_high_i,
  input wire logic cap_at_low_i,
  input wire logic line_load_zero_i,
  output logic switch_gate_drive_o,
  output logic cap_sink_on_o,
  output logic cap_source_on_o,
  output logic overvoltage_protection_o,
  output logic thermal_shutdown_o,
  output logic timer_done_o
);
  // ==========================================================
  // Timing notes
  // ==========================================================
  // Every comparator passes two sync flops, so a pin change is
  // acted on three edges later; the gate and flags show on the outputs
  // at that same edge, the sink and source pins one edge later, the done pin up to two. Supply hysteresis is left to the comparator; this
  // block only sees its level. Pulses shorter than a clock period
  // on any sense pin may be missed, which the slow mains waveform
  // never produces. The trade is a few clocks of latency against
  // metastability on pins that are fully asynchronous in practice.
  // A crossing that bounces inside one clock gives at most one
  // edge pulse, so a noisy comparator cannot switch twice.

  // ==========================================================
  // Input synchronisation
  // ==========================================================
  // All sense pins share one synchroniser so their relative timing
  // is kept; the crossing pin is the top bit of the bundle
  sense_if sense ();

  input_sync #(
    .N_IN(9)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .raw_i({line_load_zero_i, cap_at_low_i, cap_at_high_i, temp_released_i,
            over_temp_i, overvoltage_neg_i, overvoltage_pos_i, sense_in_window_i,
            supply_lockout_ok_i}),
    .sense(sense.producer)
  );

  // ==========================================================
  // Sequencer state
  // ==========================================================
  // Trip causes wait here for their own crossing edge
  seq_state_t state;
  seq_state_t next_state;
  logic gate;
  logic next_gate;
  logic trip_pos;
  logic next_trip_pos;
  logic trip_neg;
  logic next_trip_neg;
  logic trip_hot;
  logic next_trip_hot;

  // Thermal latch outlives a trip and blocks requalification
  logic hot_latch;
  logic next_hot_latch;

  // Qualification progress through the in-window mains cycle
  logic seen_rise;
  logic next_seen_rise;
  logic cycle_ok;
  logic next_cycle_ok;

  // Links to the recovery timer
  logic timer_run;
  logic sink_on;
  logic source_on;
  logic timer_done;

  // ==========================================================
  // Recovery timer
  // ==========================================================
  // Timer runs only after a full qualifying cycle was seen
  assign timer_run = ((state == ST_TIMER) || (state == ST_ARM_ON)) && cycle_ok; // see [RULE5]

  recovery_timer #(
    .CYCLES(CYCLES)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .run_i(timer_run),
    .sense(sense.consumer),
    .sink_on_o(sink_on),
    .source_on_o(source_on),
    .done_o(timer_done),
    .count_o()
  );

  // ==========================================================
  // Sequencer next state
  // ==========================================================
  // Next-state logic; lockout overrides every other decision
  always_comb begin
    next_state = state;
    next_gate = gate;
    next_trip_pos = trip_pos;
    next_trip_neg = trip_neg;
    next_trip_hot = trip_hot;
    next_seen_rise = seen_rise;
    next_cycle_ok = cycle_ok;
    if (!sense.supply_ok) begin
      // Falling threshold lives in the comparator, so hysteresis is analog
      next_state = ST_LOCKOUT; // see [RULE1] see [RULE12]
      next_gate = 1'b0; // see [RULE12]
      next_trip_pos = 1'b0;
      next_trip_neg = 1'b0;
      next_trip_hot = 1'b0;
      next_seen_rise = 1'b0;
      next_cycle_ok = 1'b0;
    end else begin
      case (state)
        // Supply just came good: start counting crossings afresh
        // so a cycle begun before lockout never counts
        ST_LOCKOUT: begin
          next_state = ST_QUALIFY; // see [RULE1]
          next_seen_rise = 1'b0;
          next_cycle_ok = 1'b0;
        end
        // Two rising crossings in window make one full cycle;
        // any excursion or heat starts the count over
        ST_QUALIFY: begin
          // A full cycle runs rising edge to rising edge, all in window
          if (!sense.in_window || hot_latch) begin
            next_seen_rise = 1'b0; // see [RULE2] see [RULE10]
            next_cycle_ok = 1'b0;
          end else if (sense.zc_rise) begin
            if (seen_rise) begin
              next_state = ST_TIMER; // see [RULE5]
            end
            next_seen_rise = 1'b1;
            next_cycle_ok = 1'b1;
          end
        end
        // Ramps run here; leaving the window throws away the
        // ramps so far and demands a new qualifying cycle
        ST_TIMER: begin
          if (!sense.in_window || hot_latch) begin
            next_state = ST_QUALIFY; // see [RULE8]
            next_seen_rise = 1'b0;
            next_cycle_ok = 1'b0;
          end else if (timer_done) begin
            next_state = ST_ARM_ON;
          end
        end
        // Interval complete; wait for a rising crossing so the
        // switch closes with no voltage across it
        ST_ARM_ON: begin
          if (!sense.in_window || hot_latch) begin
            next_state = ST_QUALIFY; // see [RULE8]
            next_seen_rise = 1'b0;
          end else if (sense.zc_rise) begin
            next_state = ST_ON; // see [RULE7]
            next_gate = 1'b1;
          end
        end
        // Heat is checked first, but an over-voltage in the same clock is
        // still latched in ST_TRIP, so a negative one can open on a rising edge
        ST_ON: begin
          if (sense.over_temp) begin
            next_trip_hot = 1'b1; // see [RULE9]
            next_state = ST_TRIP;
          end else if (sense.ov_pos) begin
            next_trip_pos = 1'b1; // see [RULE3]
            next_state = ST_TRIP;
          end else if (sense.ov_neg) begin
            next_trip_neg = 1'b1; // see [RULE3]
            next_state = ST_TRIP;
          end
        end
        // Gate stays on until the crossing that suits the cause;
        // opening away from zero volts would stress the switch
        ST_TRIP: begin
          // Late second cause still wins the earliest qualifying edge
          if (sense.ov_neg) next_trip_neg = 1'b1;
          if (sense.ov_pos) next_trip_pos = 1'b1;
          if (sense.over_temp) next_trip_hot = 1'b1;
          if ((sense.zc_fall && (trip_pos || trip_hot)) ||
              (sense.zc_rise && trip_neg)) begin
            next_gate = 1'b0; // see [RULE4] see [RULE9]
            next_state = ST_QUALIFY; // see [RULE10]
            next_trip_pos = 1'b0;
            next_trip_neg = 1'b0;
            next_trip_hot = 1'b0;
            next_seen_rise = 1'b0;
            next_cycle_ok = 1'b0;
          end
        end
        default: begin
          next_state = ST_LOCKOUT;
          next_gate = 1'b0;
        end
      endcase
    end
  end

  // Register the sequencer; reset forces the drive off
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_LOCKOUT; // see [RULE12]
      gate <= GATE_RST;
      trip_pos <= 1'b0;
      trip_neg <= 1'b0;
      trip_hot <= 1'b0;
      seen_rise <= 1'b0;
      cycle_ok <= 1'b0;
    end else begin
      state <= next_state;
      gate <= next_gate;
      trip_pos <= next_trip_pos;
      trip_neg <= next_trip_neg;
      trip_hot <= next_trip_hot;
      seen_rise <= next_seen_rise;
      cycle_ok <= next_cycle_ok;
    end
  end

  // ==========================================================
  // Thermal latch
  // ==========================================================
  // Set wins over release; supply loss keeps the latch so a hot
  // restart still waits for the junction to cool
  always_comb begin
    next_hot_latch = hot_latch;
    if (sense.supply_ok && sense.over_temp) begin
      next_hot_latch = 1'b1; // see [RULE9]
    end else if (sense.supply_ok && sense.temp_released) begin
      next_hot_latch = 1'b0; // see [RULE10]
    end
  end

  // Register the thermal latch only
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hot_latch <= 1'b0;
    end else begin
      hot_latch <= next_hot_latch;
    end
  end

  // ==========================================================
  // Output flops
  // ==========================================================
  logic next_drive;
  logic next_sink;
  logic next_source;
  logic next_ovp_flag;
  logic next_thermal_flag;
  logic next_done_flag;

  // Over-voltage and thermal flags follow the next state so they move with the gate
  always_comb begin
    next_drive = next_gate; // see [RULE1]
    next_sink = sink_on;
    next_source = source_on;
    next_ovp_flag = next_trip_pos | next_trip_neg; // see [RULE3]
    next_thermal_flag = next_hot_latch; // see [RULE9]
    next_done_flag = timer_done;
  end

  // Registers only; reset leaves every pin low
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      switch_gate_drive_o <= GATE_RST;
      cap_sink_on_o <= 1'b0;
      cap_source_on_o <= 1'b0;
      overvoltage_protection_o <= 1'b0;
      thermal_shutdown_o <= 1'b0;
      timer_done_o <= 1'b0;
    end else begin
      switch_gate_drive_o <= next_drive;
      cap_sink_on_o <= next_sink;
      cap_source_on_o <= next_source;
      overvoltage_protection_o <= next_ovp_flag;
      thermal_shutdown_o <= next_thermal_flag;
      timer_done_o <= next_done_flag;
    end
  end
endmodule : ac_switch_ovp_sequencer

// ### verif/cap_model.sv
// ==========================================================
// Timing capacitor on the recovery pin
// ==========================================================
module cap_model #(
  parameter int TOP = 15
) (
  input wire logic clk_sys_i,
  input wire logic sink_on_i,
  input wire logic source_on_i,
  output logic at_high_o,
  output logic at_low_o,
  output logic [15:0] cycles_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int level = TOP;
  logic [15:0] trips = 16'h0000;
  assign cycles_o = trips;
  // Constant-current ramp; charge is held when neither current runs
  always @(posedge clk_sys_i) begin
    if (sink_on_i && level > 0) begin
      level <= level - 1;
    end else if (source_on_i && level < TOP) begin
      level <= level + 1;
      if (level == TOP - 1) begin
        trips <= trips + 16'h0001; // Completed down-up trip
      end
    end
  end
  // Threshold comparators
  assign at_high_o = (level == TOP);
  assign at_low_o = (level == 0);
endmodule : cap_model

// ### verif/ac_switch_monitor.sv
module ac_switch_monitor
  import ac_switch_pkg::*;
#(
  parameter int unsigned CYCLES = RAMP_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic supply_lockout_ok_i,
  input wire logic sense_in_window_i,
  input wire logic overvoltage_pos_i,
  input wire logic overvoltage_neg_i,
  input wire logic over_temp_i,
  input wire logic temp_released_i,
  input wire logic cap_at_high_i,
  input wire logic cap_at_low_i,
  input wire logic line_load_zero_i,
  input wire logic switch_gate_drive_o,
  input wire logic cap_sink_on_o,
  input wire logic cap_source_on_o,
  input wire logic overvoltage_protection_o,
  input wire logic thermal_shutdown_o,
  input wire logic timer_done_o
);
  logic [7:0] rise_age;
  logic [7:0] fall_age;
  logic [7:0] sup_age;
  logic [1:0] qual;
  logic neg_seen;
  int unsigned ramps;
  logic clr;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // Helper state
  // ==========================================================
  // Qualification restarts on any of these, so counts start over
  assign clr = !sense_in_window_i || !supply_lockout_ok_i || !temp_released_i
    || switch_gate_drive_o;
  // Ages saturate so a long idle never wraps back into range
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rise_age <= 8'hff;
      fall_age <= 8'hff;
      sup_age <= 8'h00;
      qual <= 2'h0;
      neg_seen <= 1'b0;
      ramps <= 0;
    end else begin
      rise_age <= $rose(line_load_zero_i) ? 8'h00 : rise_age + {7'h00, rise_age != 8'hff};
      fall_age <= $fell(line_load_zero_i) ? 8'h00 : fall_age + {7'h00, fall_age != 8'hff};
      sup_age <= supply_lockout_ok_i ? sup_age + {7'h00, sup_age != 8'hff} : 8'h00;
      if (clr) begin
        qual <= 2'h0;
        ramps <= 0;
      end else begin
        if ($rose(line_load_zero_i) && qual != 2'h2) begin
          qual <= qual + 2'h1;
        end
        if ($rose(cap_at_high_i) && cap_source_on_o) begin
          ramps <= ramps + 1;
        end
      end
      if (overvoltage_neg_i) begin
        neg_seen <= 1'b1;
      end else if (overvoltage_pos_i || over_temp_i) begin
        neg_seen <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Properties
  // ==========================================================
  AST_RESET_CLEAR: assert property (
    $fell(sys_rst_i) |-> !switch_gate_drive_o && !timer_done_o)
    else $error("outputs not clear after reset");
  AST_LOCKOUT_OFF: assert property (
    !supply_lockout_ok_i |-> ##[1:5] !switch_gate_drive_o)
    else $error("gate on during supply lockout");
  AST_LOCKOUT_DONE: assert property (
    !supply_lockout_ok_i |-> ##[1:6] !timer_done_o)
    else $error("timer done kept during supply lockout");
  AST_ON_AT_RISE: assert property (
    $rose(switch_gate_drive_o) |-> rise_age <= 8'h07)
    else $error("gate turned on away from a rising crossing");
  AST_OFF_FALL: assert property (
    $fell(switch_gate_drive_o) && sup_age > 8'h08 && !neg_seen |-> fall_age <= 8'h07)
    else $error("gate turned off away from a falling crossing");
  AST_OFF_RISE: assert property (
    $fell(switch_gate_drive_o) && sup_age > 8'h08 && neg_seen |-> rise_age <= 8'h07)
    else $error("negative trip not on a rising crossing");
  AST_OV_FLAG: assert property (
    $rose(overvoltage_pos_i) && switch_gate_drive_o && !over_temp_i
    |-> ##[1:5] overvoltage_protection_o)
    else $error("over-voltage not flagged");
  AST_OV_CLEAR: assert property (
    $fell(switch_gate_drive_o) |-> !overvoltage_protection_o)
    else $error("over-voltage flag kept after switch off");
  AST_HOT_FLAG: assert property (
    $rose(over_temp_i) && switch_gate_drive_o |-> ##[1:5] thermal_shutdown_o)
    else $error("thermal latch not set");
  AST_QUALIFY: assert property (
    $rose(cap_sink_on_o) |-> qual == 2'h2)
    else $error("ramp began before a full in-window cycle");
  AST_RAMPS: assert property (
    $rose(timer_done_o) |-> ramps >= CYCLES)
    else $error("timer done before all ramp cycles");
endmodule : ac_switch_monitor

bind ac_switch_ovp_sequencer ac_switch_monitor #(.CYCLES(CYCLES)) mon (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .supply_lockout_ok_i(supply_lockout_ok_i),
  .sense_in_window_i(sense_in_window_i), .overvoltage_pos_i(overvoltage_pos_i),
  .overvoltage_neg_i(overvoltage_neg_i), .over_temp_i(over_temp_i),
  .temp_released_i(temp_released_i), .cap_at_high_i(cap_at_high_i),
  .cap_at_low_i(cap_at_low_i), .line_load_zero_i(line_load_zero_i),
  .switch_gate_drive_o(switch_gate_drive_o), .cap_sink_on_o(cap_sink_on_o),
  .cap_source_on_o(cap_source_on_o), .overvoltage_protection_o(overvoltage_protection_o),
  .thermal_shutdown_o(thermal_shutdown_o), .timer_done_o(timer_done_o)
);

// ### verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned SIM_CYCLES = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sup = 1'b0;
  logic win = 1'b1;
  logic ovp = 1'b0;
  logic ovn = 1'b0;
  logic hot = 1'b0;
  logic rel = 1'b1;
  logic zc = 1'b0;
  logic hi, lo, sink, src, gate, prot, tsd, done, found;
  logic [15:0] ramps, r0;
  int err_count = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  // ==========================================================
  // Design and capacitor
  // ==========================================================
  ac_switch_ovp_sequencer #(.CYCLES(SIM_CYCLES)) dut (
    .clk_sys_i(clk), .sys_rst_i(rst), .supply_lockout_ok_i(sup), .sense_in_window_i(win),
    .overvoltage_pos_i(ovp), .overvoltage_neg_i(ovn), .over_temp_i(hot),
    .temp_released_i(rel), .cap_at_high_i(hi), .cap_at_low_i(lo), .line_load_zero_i(zc),
    .switch_gate_drive_o(gate), .cap_sink_on_o(sink), .cap_source_on_o(src),
    .overvoltage_protection_o(prot), .thermal_shutdown_o(tsd), .timer_done_o(done)
  );
  cap_model cap (
    .clk_sys_i(clk), .sink_on_i(sink), .source_on_i(src), .at_high_o(hi), .at_low_o(lo),
    .cycles_o(ramps)
  );
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task check(input string what, input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  task end_of_test;
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // Inputs change 2 ns after the edge so sampling never races
  task clk1;
    @(posedge clk);
    #2;
  endtask : clk1
  // Mains half cycles of 20 clocks until the gate reaches a level
  task mains(input logic target, input int halves);
    found = 1'b0;
    for (int h = 0; h < halves; h++) begin
      zc = ~zc;
      for (int c = 0; c < 20; c++) begin
        clk1();
        if (gate === target) begin
          found = 1'b1;
          return;
        end
      end
    end
  endtask : mains
  task need(input logic target);
    mains(target, 40);
    check("gate wait", found, 1'b1);
    if (found !== 1'b1) begin
      end_of_test();
    end
  endtask : need
  // ==========================================================
  // Scenarios
  // ==========================================================
  task test_lockout;
    check("gate after reset", gate, 1'b0);
    mains(1'b1, 6);
    check("gate in lockout", found, 1'b0);
    $display("test lockout done");
  endtask : test_lockout
  task test_startup;
    sup = 1'b1;
    r0 = ramps;
    need(1'b1);
    check("zc at turn on", zc, 1'b1);
    check("ramp count", (ramps - r0) >= SIM_CYCLES, 1'b1);
    $display("test startup done");
  endtask : test_startup
  task test_ov_pos;
    ovp = 1'b1;
    win = 1'b0;
    repeat (6) clk1();
    check("pos trip flag", prot, 1'b1);
    need(1'b0);
    check("zc at pos trip", zc, 1'b0);
    check("pos flag cleared", prot, 1'b0);
    ovp = 1'b0;
    win = 1'b1;
    need(1'b1);
    check("zc at recovery", zc, 1'b1);
    $display("test pos trip done");
  endtask : test_ov_pos
  task test_ov_neg_window;
    ovn = 1'b1;
    win = 1'b0;
    repeat (6) clk1();
    check("neg trip flag", prot, 1'b1);
    need(1'b0);
    check("zc at neg trip", zc, 1'b1);
    ovn = 1'b0;
    win = 1'b1;
    mains(1'b1, 8);
    check("gate mid timer", found, 1'b0);
    win = 1'b0;
    repeat (4) clk1();
    win = 1'b1;
    r0 = ramps;
    need(1'b1);
    check("ramps after break", (ramps - r0) >= SIM_CYCLES, 1'b1);
    $display("test neg trip and window break done");
  endtask : test_ov_neg_window
  task test_thermal;
    hot = 1'b1;
    rel = 1'b0;
    repeat (6) clk1();
    need(1'b0);
    check("zc at thermal trip", zc, 1'b0);
    check("thermal latch", tsd, 1'b1);
    hot = 1'b0;
    mains(1'b1, 8);
    check("gate while warm", found, 1'b0);
    rel = 1'b1;
    r0 = ramps;
    need(1'b1);
    check("ramps after cooling", (ramps - r0) >= SIM_CYCLES, 1'b1);
    check("latch released", tsd, 1'b0);
    $display("test thermal done");
  endtask : test_thermal
  task test_supply_drop;
    sup = 1'b0;
    repeat (6) clk1();
    check("gate on supply drop", gate, 1'b0);
    check("done on supply drop", done, 1'b0);
    check("sink on supply drop", sink, 1'b0);
    check("source on supply drop", src, 1'b0);
    sup = 1'b1;
    need(1'b1);
    $display("test supply drop done");
  endtask : test_supply_drop
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #2;
    rst = 1'b0;
    test_lockout();
    test_startup();
    test_ov_pos();
    test_ov_neg_window();
    test_thermal();
    test_supply_drop();
    end_of_test();
  end
endmodule : testbench
